// >>> shared/lcr_pkg.sv
// constants for the link controller configuration registers
// assumes a host bus clocked by the system clock, register pointer selection
package lcr_pkg;
  // ---------------------------------------------------------------
  // register pointer indices
  // ---------------------------------------------------------------
  localparam logic [2:0] LCR_IDX_OPT = 3'h2; // options and base high
  localparam logic [2:0] LCR_IDX_BASE = 3'h3; // base low
  localparam logic [2:0] LCR_IDX_WDOG = 3'h4; // bus master and watchdogs
  localparam logic [15:0] LCR_RST_VAL = 16'h0000; // all fields clear on reset
  // ---------------------------------------------------------------
  // field positions, options register
  // ---------------------------------------------------------------
  localparam int LCR_B_SHORT = 15;
  localparam int LCR_B_EXT = 14;
  localparam int LCR_B_RSUP = 13;
  localparam int LCR_B_IDLE = 12;
  localparam int LCR_B_X75 = 11;
  localparam int LCR_B_PROMISCUOUS_RECEIVE = 10;
  localparam int LCR_B_UI = 9;
  localparam int LCR_B_XID = 8;
  localparam int LCR_B_BASEH = 0; // 7:0
  // ---------------------------------------------------------------
  // field positions, watchdog register
  // ---------------------------------------------------------------
  localparam int LCR_B_TXWD = 14; // 15:14
  localparam int LCR_B_RXWD = 12; // 13:12
  localparam int LCR_B_ODD = 11;
  localparam int LCR_B_HOLD = 10;
  localparam int LCR_B_FWM = 8; // 9:8
  localparam int LCR_B_BAE = 7;
  localparam int LCR_B_BUS_RELEASE_SELECT = 6;
  localparam int LCR_B_BCON = 0;
  // ---------------------------------------------------------------
  // dma cycle lengths in system clocks
  // ---------------------------------------------------------------
  localparam logic [2:0] LCR_CYC_SHORT = 3'h5;
  localparam logic [2:0] LCR_CYC_BURST = 3'h6;
  localparam logic [2:0] LCR_CYC_SINGLE = 3'h7;
  // ---------------------------------------------------------------
  // init block offsets in extended layout
  // ---------------------------------------------------------------
  localparam logic [7:0] LCR_OFS_SCALER = 8'h08;
  localparam logic [7:0] LCR_OFS_RETRY_EXT = 8'h28;
  localparam logic [7:0] LCR_OFS_LAST_EXT = 8'h37;
  // ---------------------------------------------------------------
  // watermark thresholds in 16-bit words
  // ---------------------------------------------------------------
  localparam logic [5:0] LCR_WM_10 = 6'h09;
  localparam logic [5:0] LCR_WM_01 = 6'h11;
  localparam logic [5:0] LCR_WM_00 = 6'h19;
  localparam logic [5:0] LCR_HO_10 = 6'h13;
  localparam logic [5:0] LCR_HO_01 = 6'h0B;
  localparam logic [5:0] LCR_HO_00 = 6'h03;
  // ---------------------------------------------------------------
  // provider primitive report
  // ---------------------------------------------------------------
  localparam logic [3:0] LCR_PRIM_WDOG = 4'h3;
  localparam logic [1:0] LCR_PARM_TX = 2'h1;
  localparam logic [1:0] LCR_PARM_RX = 2'h2;
  // received frame kinds seen by the filter
  typedef enum logic [1:0] {LCR_FR_OTHER, LCR_FR_UI, LCR_FR_XID} lcr_frame_t;
endpackage

// >>> shared/lcr_wd_if.sv
// carrier between the register bank and one clock watchdog
// assumes both ends run on the system clock
`timescale 1ns/100ps
`default_nettype none
interface lcr_wd_if;
  logic [1:0] sel; // 00 off, else length code
  logic kick; // pin transition seen
  logic expire; // one-cycle expiry pulse
  modport ctl (output sel, output kick, input expire);
  modport tmr (input sel, input kick, output expire);
endinterface
`default_nettype wire

// >>> hdl/lcr_watchdog.sv
// one serial clock watchdog counting system clocks between pin transitions
// assumes a synchronous kick and a reset already synchronised
`timescale 1ns/100ps
`default_nettype none
module lcr_watchdog
  import lcr_pkg::*;
#(
  parameter int EXP_BASE = 18 // log2 of the shortest period
) (
  input wire logic clk,
  input wire logic rst_n,
  lcr_wd_if.tmr wd
);
  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [EXP_BASE+2:0] cnt; // cycles since last transition
    logic fired; // expiry already reported
    logic pulse; // expiry strobe
  } lcr_wd_st_t;
  lcr_wd_st_t st_ff;
  lcr_wd_st_t nxt_st;

  // terminal count for a select code
  function automatic logic [EXP_BASE+2:0] lcr_limit(input logic [1:0] s);
    logic [EXP_BASE+2:0] one;
    one = {{(EXP_BASE+2){1'b0}}, 1'b1};
    unique case (s)
      2'h1: lcr_limit = one << EXP_BASE;
      2'h2: lcr_limit = one << (EXP_BASE + 1);
      default: lcr_limit = one << (EXP_BASE + 2);
    endcase
  endfunction

  // count, restart on transition, fire once
  always_comb begin
    nxt_st = st_ff;
    nxt_st.pulse = 1'b0;
    if (wd.sel == 2'h0 || wd.kick) begin
      nxt_st.cnt = '0;
      nxt_st.fired = 1'b0;
    end else if (!st_ff.fired) begin
      if (st_ff.cnt + (EXP_BASE+3)'(1) >= lcr_limit(wd.sel)) begin
        nxt_st.pulse = 1'b1;
        nxt_st.fired = 1'b1;
      end else begin
        nxt_st.cnt = st_ff.cnt + (EXP_BASE+3)'(1);
      end
    end
  end

  // register the state
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign wd.expire = st_ff.pulse;
endmodule // lcr_watchdog
`default_nettype wire

// >>> hdl/lcr_config_regs.sv
// configuration register bank of the link controller plus the logic it steers
// assumes host strobes on the system clock; serial clocks and bus release are pins
`timescale 1ns/100ps
`default_nettype none
module lcr_config_regs
  import lcr_pkg::*;
#(
  parameter int WD_EXP_BASE = 18, // shortest watchdog period as power of two
  parameter logic [7:0] OFS_RETRY_STD = 8'h0A, // retry count offset, normal layout
  parameter logic [7:0] OFS_LAST_STD = 8'h1E // last block offset, normal layout
) (
  input wire logic clk,
  input wire logic rst_n,
  // host register port
  input wire logic host_sel,
  input wire logic host_ptr_sel,
  input wire logic host_wr,
  input wire logic host_rd,
  input wire logic [15:0] host_wdata,
  output logic [15:0] host_rdata,
  // dma engine
  input wire logic dma_burst,
  output logic [2:0] dma_cycle_clocks,
  output logic [23:0] setup_block_base,
  output logic extended_block_enable,
  output logic [7:0] scaler_offset,
  output logic scaler_is_word,
  output logic [7:0] retry_count_offset,
  output logic [7:0] block_last_offset,
  // protocol engine
  output logic reject_frame_suppress,
  output logic idle_timer_mode,
  output logic interexchange_variant_enable,
  input wire logic transparent_mode,
  output logic skip_addr_filter,
  input wire logic rx_frame_done,
  input wire logic rx_frame_good,
  input wire logic rx_addr_match,
  input wire lcr_frame_t rx_frame_kind,
  output logic rx_frame_accept,
  input wire logic rx_any_frame,
  output logic idle_timer_restart,
  // fifos
  input wire logic rx_first_byte,
  output logic rx_dup_first_byte,
  input wire logic [5:0] rx_fifo_words,
  input wire logic rx_end_of_frame,
  output logic rx_dma_allowed,
  input wire logic [5:0] tx_fifo_free,
  input wire logic [5:0] tx_fifo_words,
  input wire logic tx_frame_loaded,
  output logic tx_fetch_allowed,
  output logic tx_start_allowed,
  // bus pins
  input wire logic addr_phase_drive,
  output logic upper_addr_oe,
  input wire logic bus_release_input,
  output logic bus_release_active,
  output logic byte_mask_low_mode,
  // serial clock pins
  input wire logic tx_serial_clock,
  input wire logic rx_serial_clock,
  // provider primitive report
  output logic prim_valid,
  output logic [3:0] provider_primitive_code,
  output logic [1:0] provider_parameter,
  output logic primitive_lost_flag
);
  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [2:0] ptr; // register pointer
    logic [15:0] opt; // options and base high
    logic [15:0] base; // base low
    logic [15:0] wdog; // bus master and watchdog config
    logic [15:0] rdata; // read data
    logic [1:0] tx_sync; // tx clock synchroniser
    logic [1:0] rx_sync; // rx clock synchroniser
    logic tx_last; // previous synced tx clock
    logic rx_last; // previous synced rx clock
    logic [1:0] rel_sync; // bus release synchroniser
    logic prim; // primitive strobe
    logic [3:0] code; // primitive code
    logic [1:0] parm; // primitive parameter
    logic lost; // both expired together
  } lcr_st_t;
  lcr_st_t st_ff;
  lcr_st_t nxt_st;
  logic [1:0] rst_sync_ff; // reset release stages
  logic rst_int_n; // synchronised reset

  lcr_wd_if tx_wd ();
  lcr_wd_if rx_wd ();

  // ---------------------------------------------------------------
  // reset release
  // ---------------------------------------------------------------
  // two stages so deassertion meets timing
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_sync_ff <= 2'h0;
    end else begin
      rst_sync_ff <= {rst_sync_ff[0], 1'b1};
    end
  end
  assign rst_int_n = rst_sync_ff[1];

  // watermark decode, shared by receive and transmit paths
  function automatic logic [5:0] lcr_fwm(input logic [1:0] c);
    unique case (c)
      2'h2: lcr_fwm = LCR_WM_10;
      2'h1: lcr_fwm = LCR_WM_01;
      default: lcr_fwm = LCR_WM_00;
    endcase
  endfunction

  // hold-off threshold decode
  function automatic logic [5:0] lcr_hold(input logic [1:0] c);
    unique case (c)
      2'h2: lcr_hold = LCR_HO_10;
      2'h1: lcr_hold = LCR_HO_01;
      default: lcr_hold = LCR_HO_00;
    endcase
  endfunction

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    logic tx_exp;
    logic rx_exp;
    tx_exp = tx_wd.expire;
    rx_exp = rx_wd.expire;
    nxt_st = st_ff;
    // pin synchronisers
    nxt_st.tx_sync = {st_ff.tx_sync[0], tx_serial_clock};
    nxt_st.rx_sync = {st_ff.rx_sync[0], rx_serial_clock};
    nxt_st.tx_last = st_ff.tx_sync[1];
    nxt_st.rx_last = st_ff.rx_sync[1];
    nxt_st.rel_sync = {st_ff.rel_sync[0], bus_release_input};
    // host writes
    if (host_sel && host_wr) begin
      if (host_ptr_sel) begin
        nxt_st.ptr = host_wdata[3:1];
      end else begin
        unique case (st_ff.ptr)
          LCR_IDX_OPT: nxt_st.opt = host_wdata;
          LCR_IDX_BASE: nxt_st.base = host_wdata;
          LCR_IDX_WDOG: nxt_st.wdog = host_wdata;
          default: ; // unmapped index ignored
        endcase
      end
    end
    // host reads, registered
    if (host_sel && host_rd) begin
      if (host_ptr_sel) begin
        nxt_st.rdata = {12'h000, st_ff.ptr, 1'b0};
      end else begin
        unique case (st_ff.ptr)
          LCR_IDX_OPT: nxt_st.rdata = st_ff.opt;
          LCR_IDX_BASE: nxt_st.rdata = st_ff.base;
          LCR_IDX_WDOG: nxt_st.rdata = st_ff.wdog;
          default: nxt_st.rdata = 16'h0000; // unmapped reads zero
        endcase
      end
    end
    // watchdog expiry report
    nxt_st.prim = tx_exp | rx_exp;
    if (tx_exp | rx_exp) begin
      nxt_st.code = LCR_PRIM_WDOG;
      nxt_st.parm = tx_exp ? LCR_PARM_TX : LCR_PARM_RX;
      nxt_st.lost = tx_exp & rx_exp;
    end
  end

  // ---------------------------------------------------------------
  // state register
  // ---------------------------------------------------------------
  // every field returns to zero on bus reset
  always_ff @(posedge clk or negedge rst_int_n) begin
    if (!rst_int_n) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ---------------------------------------------------------------
  // watchdogs
  // ---------------------------------------------------------------
  assign tx_wd.sel = st_ff.wdog[LCR_B_TXWD +: 2];
  assign rx_wd.sel = st_ff.wdog[LCR_B_RXWD +: 2];
  // any edge of the synced serial clock restarts the count
  assign tx_wd.kick = st_ff.tx_sync[1] ^ st_ff.tx_last;
  assign rx_wd.kick = st_ff.rx_sync[1] ^ st_ff.rx_last;

  lcr_watchdog #(
    .EXP_BASE(WD_EXP_BASE)
  ) u_tx_wd (
    .clk(clk),
    .rst_n(rst_int_n),
    .wd(tx_wd)
  );

  lcr_watchdog #(
    .EXP_BASE(WD_EXP_BASE)
  ) u_rx_wd (
    .clk(clk),
    .rst_n(rst_int_n),
    .wd(rx_wd)
  );

  // ---------------------------------------------------------------
  // host read data and primitive report
  // ---------------------------------------------------------------
  assign host_rdata = st_ff.rdata;
  assign prim_valid = st_ff.prim;
  assign provider_primitive_code = st_ff.code;
  assign provider_parameter = st_ff.parm;
  assign primitive_lost_flag = st_ff.lost;

  // ---------------------------------------------------------------
  // dma engine controls
  // ---------------------------------------------------------------
  // short cycle wins over the transfer kind
  assign dma_cycle_clocks = st_ff.opt[LCR_B_SHORT] ? LCR_CYC_SHORT :
                            (dma_burst ? LCR_CYC_BURST : LCR_CYC_SINGLE);
  // bit zero is the host's to keep even
  assign setup_block_base = {st_ff.opt[LCR_B_BASEH +: 8], st_ff.base};
  assign extended_block_enable = st_ff.opt[LCR_B_EXT];
  assign scaler_offset = LCR_OFS_SCALER;
  assign scaler_is_word = st_ff.opt[LCR_B_EXT];
  assign retry_count_offset = st_ff.opt[LCR_B_EXT] ? LCR_OFS_RETRY_EXT : OFS_RETRY_STD;
  assign block_last_offset = st_ff.opt[LCR_B_EXT] ? LCR_OFS_LAST_EXT : OFS_LAST_STD;

  // ---------------------------------------------------------------
  // protocol engine controls
  // ---------------------------------------------------------------
  assign reject_frame_suppress = st_ff.opt[LCR_B_RSUP];
  assign idle_timer_mode = st_ff.opt[LCR_B_IDLE];
  // in idle mode every received frame restarts the timer
  assign idle_timer_restart = st_ff.opt[LCR_B_IDLE] & rx_any_frame;
  assign interexchange_variant_enable = st_ff.opt[LCR_B_X75];
  assign skip_addr_filter = st_ff.opt[LCR_B_PROMISCUOUS_RECEIVE] & transparent_mode;

  // frame filter: good frame, address or promiscuous, kind enabled
  always_comb begin
    logic kind_ok;
    kind_ok = 1'b1;
    unique case (rx_frame_kind)
      LCR_FR_UI: kind_ok = st_ff.opt[LCR_B_UI];
      LCR_FR_XID: kind_ok = st_ff.opt[LCR_B_XID];
      default: kind_ok = 1'b1;
    endcase
    rx_frame_accept = rx_frame_done & rx_frame_good & kind_ok &
                      (rx_addr_match | skip_addr_filter);
  end

  // ---------------------------------------------------------------
  // fifo thresholds
  // ---------------------------------------------------------------
  assign rx_dup_first_byte = st_ff.wdog[LCR_B_ODD] & rx_first_byte;
  assign rx_dma_allowed = (rx_fifo_words >= lcr_fwm(st_ff.wdog[LCR_B_FWM +: 2])) |
                          rx_end_of_frame;
  assign tx_fetch_allowed = tx_fifo_free >= lcr_fwm(st_ff.wdog[LCR_B_FWM +: 2]);
  assign tx_start_allowed = !st_ff.wdog[LCR_B_HOLD] | tx_frame_loaded |
                            (tx_fifo_words >= lcr_hold(st_ff.wdog[LCR_B_FWM +: 2]));

  // ---------------------------------------------------------------
  // bus pin controls
  // ---------------------------------------------------------------
  // constant drive for bank select, else follow the low address pins
  assign upper_addr_oe = st_ff.wdog[LCR_B_BAE] | addr_phase_drive;
  // release input only honoured while the pin is in that role
  assign bus_release_active = st_ff.wdog[LCR_B_BUS_RELEASE_SELECT] & st_ff.rel_sync[1];
  assign byte_mask_low_mode = !st_ff.wdog[LCR_B_BUS_RELEASE_SELECT] & !st_ff.wdog[LCR_B_BCON];
endmodule // lcr_config_regs
`default_nettype wire

// >>> sim/lcr_config_regs_properties.sv
// port checker for the link controller configuration registers
// assumes binding to lcr_config_regs; it shadows host writes itself
`timescale 1ns/100ps
`default_nettype none
module lcr_config_regs_properties
  import lcr_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic host_sel,
  input wire logic host_ptr_sel,
  input wire logic host_wr,
  input wire logic [15:0] host_wdata,
  input wire logic dma_burst,
  input wire logic [2:0] dma_cycle_clocks,
  input wire logic extended_block_enable,
  input wire logic [7:0] retry_count_offset,
  input wire logic transparent_mode,
  input wire logic skip_addr_filter,
  input wire logic rx_any_frame,
  input wire logic idle_timer_restart,
  input wire logic [5:0] rx_fifo_words,
  input wire logic rx_end_of_frame,
  input wire logic rx_dma_allowed,
  input wire logic [5:0] tx_fifo_words,
  input wire logic tx_frame_loaded,
  input wire logic tx_start_allowed,
  input wire logic upper_addr_oe,
  input wire logic prim_valid,
  input wire logic [3:0] provider_primitive_code
);
  // ---------------------------------------------
  // shadow registers
  // ---------------------------------------------
  logic [2:0] ptr_ff; // register pointer copy
  logic [15:0] opt_ff; // options copy
  logic [15:0] wd_ff; // watchdog register copy
  logic [5:0] wm; // dma watermark in words
  logic [5:0] ho; // hold-off threshold in words
  // capture host writes the way the block takes them
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ptr_ff <= 3'h0;
      opt_ff <= 16'h0000;
      wd_ff <= 16'h0000;
    end else if (host_sel && host_wr) begin
      if (host_ptr_sel) ptr_ff <= host_wdata[3:1];
      else if (ptr_ff == LCR_IDX_OPT) opt_ff <= host_wdata;
      else if (ptr_ff == LCR_IDX_WDOG) wd_ff <= host_wdata;
    end
  end
  assign wm = (wd_ff[9:8] == 2'h2) ? LCR_WM_10 : (wd_ff[9:8] == 2'h1) ? LCR_WM_01 : LCR_WM_00;
  assign ho = (wd_ff[9:8] == 2'h2) ? LCR_HO_10 : (wd_ff[9:8] == 2'h1) ? LCR_HO_01 : LCR_HO_00;
  // ---------------------------------------------
  // properties
  // ---------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  property p_cycle_len;
    dma_cycle_clocks == (opt_ff[15] ? LCR_CYC_SHORT : dma_burst ? LCR_CYC_BURST : LCR_CYC_SINGLE);
  endproperty
  a_cycle_len: assert property (p_cycle_len) else $error("dma cycle length wrong");
  property p_ext_layout;
    $rose(opt_ff[14]) |-> extended_block_enable && retry_count_offset == LCR_OFS_RETRY_EXT;
  endproperty
  a_ext_layout: assert property (p_ext_layout) else $error("extended layout not applied");
  property p_skip;
    skip_addr_filter == (opt_ff[10] && transparent_mode);
  endproperty
  a_skip: assert property (p_skip) else $error("address filter skip wrong");
  property p_idle;
    rx_any_frame |-> idle_timer_restart == opt_ff[12];
  endproperty
  a_idle: assert property (p_idle) else $error("idle timer restart wrong");
  property p_rx_dma;
    rx_dma_allowed == (rx_fifo_words >= wm || rx_end_of_frame);
  endproperty
  a_rx_dma: assert property (p_rx_dma) else $error("receive dma gate wrong");
  property p_hold;
    wd_ff[10] && !tx_frame_loaded && tx_fifo_words < ho |-> !tx_start_allowed;
  endproperty
  a_hold: assert property (p_hold) else $error("transmit start not held off");
  property p_upper_addr;
    wd_ff[7] |-> upper_addr_oe;
  endproperty
  a_upper_addr: assert property (p_upper_addr) else $error("upper address not driven");
  property p_wd_enabled;
    prim_valid |-> $past(wd_ff[15:12], 2) != 4'h0;
  endproperty
  a_wd_enabled: assert property (p_wd_enabled) else $error("report from disabled watchdog");
  property p_prim_code;
    prim_valid |-> (provider_primitive_code == LCR_PRIM_WDOG) ##1 (provider_primitive_code == LCR_PRIM_WDOG);
  endproperty
  a_prim_code: assert property (p_prim_code) else $error("primitive code wrong");
  c_prim: cover property (prim_valid);
  c_short: cover property (dma_cycle_clocks == LCR_CYC_SHORT);
  c_wm: cover property (rx_dma_allowed && !rx_end_of_frame);
endmodule // lcr_config_regs_properties
bind lcr_config_regs lcr_config_regs_properties i_props (.*);
`default_nettype wire

// >>> sim/lcr_host_model.sv
// host processor model driving the register port
// assumes tasks are entered just after a rising edge of clk
`timescale 1ns/100ps
`default_nettype none
module lcr_host_model
  import lcr_pkg::*;
(
  input wire logic clk,
  output var logic host_sel,
  output var logic host_ptr_sel,
  output var logic host_wr,
  output var logic host_rd,
  output var logic [15:0] host_wdata
);
  // idle bus at time zero
  initial begin
    host_sel = 1'b0;
    host_ptr_sel = 1'b0;
    host_wr = 1'b0;
    host_rd = 1'b0;
    host_wdata = 16'h0000;
  end
  // one strobe cycle, released after the taking edge
  task automatic put(input logic p, input logic w, input logic r, input logic [15:0] d);
    host_ptr_sel = p;
    host_wr = w;
    host_rd = r;
    host_wdata = d;
    host_sel = 1'b1;
    @(posedge clk);
    #1;
    host_sel = 1'b0;
    host_wr = 1'b0;
    host_rd = 1'b0;
    host_wdata = ~d; // released data does not keep its value
    @(posedge clk); // idle edge before the next strobe
    #1;
  endtask
  // pointer first, then the data cycle; block base kept even
  task automatic wr_reg(input logic [2:0] idx, input logic [15:0] d);
    put(1'b1, 1'b1, 1'b0, {12'h000, idx, 1'b0});
    put(1'b0, 1'b1, 1'b0, (idx == LCR_IDX_BASE) ? (d & 16'hFFFE) : d);
  endtask
  task automatic rd_reg(input logic [2:0] idx);
    put(1'b1, 1'b1, 1'b0, {12'h000, idx, 1'b0});
    put(1'b0, 1'b0, 1'b1, 16'h0000);
  endtask
endmodule // lcr_host_model
`default_nettype wire

// >>> sim/lcr_config_regs_tb.sv
// self-checking bench for the configuration register bank
// assumes host model and checker files compiled before this one
`timescale 1ns/100ps
`default_nettype none
module lcr_config_regs_tb
  import lcr_pkg::*;
;
  logic clk, rst_n, host_sel, host_ptr_sel, host_wr, host_rd;
  logic [15:0] host_wdata, host_rdata;
  logic dma_burst, transparent_mode, rx_frame_done, rx_frame_good, rx_addr_match, rx_any_frame, rx_first_byte;
  lcr_frame_t rx_frame_kind;
  logic [5:0] rx_fifo_words, tx_fifo_free, tx_fifo_words, wm, ho;
  logic rx_end_of_frame, tx_frame_loaded, addr_phase_drive, bus_release_input, tx_serial_clock, rx_serial_clock;
  logic [2:0] dma_cycle_clocks;
  logic [23:0] setup_block_base;
  logic [7:0] scaler_offset, retry_count_offset, block_last_offset;
  logic extended_block_enable, scaler_is_word, reject_frame_suppress, idle_timer_mode, interexchange_variant_enable;
  logic skip_addr_filter, rx_frame_accept, idle_timer_restart, rx_dup_first_byte, rx_dma_allowed, tx_fetch_allowed;
  logic tx_start_allowed, upper_addr_oe, bus_release_active, byte_mask_low_mode, prim_valid, primitive_lost_flag;
  logic [3:0] provider_primitive_code;
  logic [1:0] provider_parameter;
  logic [15:0] opt, base, wd;
  logic [15:0] rd_q[$]; // expected read data
  logic [6:0] prim_q[$]; // expected code, parameter, lost
  logic rd_seen, kok;
  int err_total, tests_run, k, n;
  lcr_config_regs #(.WD_EXP_BASE(4)) i_dut (.*);
  lcr_host_model i_host (.*);
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // one comparison, counted
  task automatic chk(input string nm, input logic [23:0] exp, input logic [23:0] got);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // ---------------------------------------------
  // result watcher
  // ---------------------------------------------
  always @(posedge clk) begin
    if (rd_seen) chk("host_rdata", (rd_q.size() != 0) ? 24'(rd_q.pop_front()) : 24'hFFFFFF, 24'(host_rdata));
    if (prim_valid === 1'b1) begin
      chk("report", (prim_q.size() != 0) ? 24'(prim_q.pop_front()) : 24'hFFFFFF,
          24'({provider_primitive_code, provider_parameter, primitive_lost_flag}));
    end
    rd_seen = host_sel && host_rd;
  end
  // bounded wait for the pending report; n counts cycles
  task automatic wait_prim;
    n = 0;
    while (prim_q.size() != 0 && n < 300) begin
      @(posedge clk);
      n++;
    end
    #1;
    if (n >= 300) chk("report wait", 24'h1, 24'h0);
  endtask
  // random register values, readback, then the steered outputs
  task automatic comb_case(input logic [1:0] code);
    transparent_mode = 1'($urandom);
    bus_release_input = 1'($urandom);
    opt = 16'($urandom);
    if (!transparent_mode) opt[10] = 1'b0;
    base = 16'($urandom) & 16'hFFFE;
    wd = (16'($urandom) & 16'h0CFF) | {6'h00, code, 8'h00};
    i_host.wr_reg(LCR_IDX_OPT, opt);
    i_host.wr_reg(LCR_IDX_BASE, base);
    i_host.wr_reg(LCR_IDX_WDOG, wd);
    rd_q.push_back(opt);
    i_host.rd_reg(LCR_IDX_OPT);
    rd_q.push_back(base);
    i_host.rd_reg(LCR_IDX_BASE);
    rd_q.push_back(wd);
    i_host.rd_reg(LCR_IDX_WDOG);
    {dma_burst, rx_frame_done, rx_frame_good, rx_addr_match, rx_any_frame} = 5'($urandom);
    {rx_first_byte, rx_end_of_frame, tx_frame_loaded, addr_phase_drive} = 4'($urandom);
    rx_frame_kind = lcr_frame_t'($urandom % 3);
    wm = (code == 2'h2) ? 6'h09 : (code == 2'h1) ? 6'h11 : 6'h19;
    ho = (code == 2'h2) ? 6'h13 : (code == 2'h1) ? 6'h0B : 6'h03;
    rx_fifo_words = wm - 6'($urandom % 2);
    tx_fifo_free = wm - 6'($urandom % 2);
    tx_fifo_words = ho - 6'($urandom % 2);
    kok = (rx_frame_kind == LCR_FR_UI) ? opt[9] : (rx_frame_kind == LCR_FR_XID) ? opt[8] : 1'b1;
    #1;
    chk("cycle", 24'({opt[15] ? 3'h5 : dma_burst ? 3'h6 : 3'h7, 8'h08}),
        24'({dma_cycle_clocks, scaler_offset}));
    chk("base", {opt[7:0], base}, setup_block_base);
    chk("layout", 24'({opt[14], opt[14], opt[14] ? 16'h2837 : 16'h0A1E}),
        24'({extended_block_enable, scaler_is_word, retry_count_offset, block_last_offset}));
    chk("proto", 24'(opt[13:11]), 24'({reject_frame_suppress, idle_timer_mode, interexchange_variant_enable}));
    chk("accept", 24'(rx_frame_done && rx_frame_good && kok && (rx_addr_match || (opt[10] && transparent_mode))),
        24'(rx_frame_accept));
    chk("rx", 24'({rx_any_frame && opt[12], wd[11] && rx_first_byte, rx_fifo_words >= wm || rx_end_of_frame}),
        24'({idle_timer_restart, rx_dup_first_byte, rx_dma_allowed}));
    chk("tx", 24'({tx_fifo_free >= wm, !wd[10] || tx_frame_loaded || tx_fifo_words >= ho}),
        24'({tx_fetch_allowed, tx_start_allowed}));
    chk("pins", 24'({wd[7] || addr_phase_drive, wd[6] && bus_release_input, !wd[6] && !wd[0]}),
        24'({upper_addr_oe, bus_release_active, byte_mask_low_mode}));
  endtask
  // ---------------------------------------------
  // main sequence
  // ---------------------------------------------
  initial begin
    {rst_n, dma_burst, transparent_mode, rx_frame_done, rx_frame_good, rx_addr_match, rx_any_frame} = 7'h00;
    {rx_first_byte, rx_end_of_frame, tx_frame_loaded, addr_phase_drive, bus_release_input} = 5'h00;
    {tx_serial_clock, rx_serial_clock, rd_seen} = 3'h0;
    {rx_fifo_words, tx_fifo_free, tx_fifo_words} = 18'h00000;
    rx_frame_kind = LCR_FR_OTHER;
    err_total = 0;
    tests_run = 0;
    k = $urandom(7);
    repeat (20) @(posedge clk);
    #1 rst_n = 1'b1;
    repeat (3) @(posedge clk);
    #1;
    for (k = 2; k <= 4; k++) begin
      rd_q.push_back(16'h0000);
      i_host.rd_reg(3'(k));
    end
    i_host.wr_reg(3'h5, 16'hFFFF);
    rd_q.push_back(16'h0000);
    i_host.rd_reg(3'h5);
    rd_q.push_back(16'h000A);
    i_host.put(1'b1, 1'b0, 1'b1, 16'h0000);
    $display("test reset and unmapped done");
    for (k = 0; k < 24; k++) comb_case(2'(k % 3));
    $display("test register fields done");
    i_host.wr_reg(LCR_IDX_WDOG, 16'h4000);
    repeat (12) begin
      repeat (8) @(posedge clk);
      #1 tx_serial_clock = ~tx_serial_clock;
    end
    prim_q.push_back({4'h3, 2'h1, 1'b0});
    wait_prim();
    for (k = 1; k <= 3; k++) begin
      i_host.wr_reg(LCR_IDX_WDOG, 16'h0000);
      i_host.wr_reg(LCR_IDX_WDOG, 16'(k << 12));
      prim_q.push_back({4'h3, 2'h2, 1'b0});
      wait_prim();
      chk("period", 24'h1, 24'(n >= (6 << k) && n <= (8 << k) + 10));
    end
    i_host.wr_reg(LCR_IDX_WDOG, 16'h0000);
    i_host.wr_reg(LCR_IDX_WDOG, 16'h5000);
    prim_q.push_back({4'h3, 2'h1, 1'b1});
    wait_prim();
    $display("test watchdogs done");
    tally_and_finish();
  end
  // watchdog against a hang
  initial begin
    #200000;
    err_total++;
    tally_and_finish();
  end
endmodule // lcr_config_regs_tb
`default_nettype wire
